// [verilog/uers_pkg.sv]
`default_nettype none
package uers_pkg;
  localparam logic [7:0] DEV_CTRL = 8'h05;
  localparam logic [7:0] INT_EN   = 8'h06;
  localparam logic [7:0] DEV_ADDR = 8'h07;
  localparam logic [7:0] INT_STAT = 8'h0d;
  localparam logic [7:0] CUR_SET  = 8'h0e;
  localparam logic [7:0] FRM_LO   = 8'h15;
  localparam logic [7:0] FRM_HI   = 8'h16;
  localparam logic [7:0] DMA_LO   = 8'h35;
  localparam logic [7:0] DMA_HI   = 8'h36;
  localparam logic [7:0] BUF_BASE = 8'h40;
  localparam logic [7:0] MEM_RST  = 8'h00;
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_PTR  = 3'h1;
  localparam logic [2:0] OFS_LEN  = 3'h2;
  localparam logic [2:0] OFS_STAT = 3'h3;
  localparam logic [2:0] OFS_RES  = 3'h4;
  localparam logic [2:0] OFS_LAST = 3'h4;
  localparam int C_ARM   = 0;
  localparam int C_EN    = 1;
  localparam int C_DIR   = 2;
  localparam int C_NEXT  = 3;
  localparam int C_ISO   = 4;
  localparam int C_STALL = 5;
  localparam int C_SEQ   = 6;
  localparam int C_RSVD  = 7;
  localparam int S_ACK   = 0;
  localparam int S_ERR   = 1;
  localparam int S_TMO   = 2;
  localparam int S_SEQ   = 3;
  localparam int S_SETUP = 4;
  localparam int S_OVF   = 5;
  localparam int S_NAK   = 6;
  localparam int S_STALL = 7;
  localparam int D_USB_EN = 0;
  localparam int I_SOF   = 5;
  localparam int I_RST   = 6;
  localparam int I_DMA   = 7;
  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} uers_tok_t;
  typedef enum logic [1:0] {RSP_IGNORE, RSP_GO, RSP_NAK, RSP_STALL} uers_rsp_t;
  typedef struct packed {
    logic [1:0] ep;
    uers_tok_t  kind;
    logic [6:0] addr;
  } uers_tok_req_t;
  typedef struct packed {
    uers_rsp_t  code;
    logic       iso;
    logic       seq;
    logic [7:0] ptr;
    logic [7:0] len;
  } uers_rsp_pkt_t;
  typedef struct packed {
    logic [1:0] ep;
    logic       ack;
    logic       err;
    logic       tmo;
    logic       seq;
    logic       setup;
    logic [7:0] count;
  } uers_done_t;
endpackage
`default_nettype wire

// [verilog/uers_top.sv]
`timescale 1ns/1ps
`default_nettype none
module uers_top (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    cs_n,
  input  wire logic                    rd_n,
  input  wire logic                    wr_n,
  input  wire logic                    register_index_select,
  input  wire logic [7:0]              data_in,
  output logic      [7:0]              data_out,
  output logic                         data_oe_n,
  input  wire logic                    tok_valid,
  input  wire uers_pkg::uers_tok_req_t tok,
  output logic                         rsp_valid,
  output uers_pkg::uers_rsp_pkt_t      rsp,
  input  wire logic                    done_valid,
  input  wire uers_pkg::uers_done_t    done,
  input  wire logic                    buf_we,
  input  wire logic [7:0]              buf_addr,
  input  wire logic [7:0]              buf_wdata,
  output logic      [7:0]              buf_rdata,
  input  wire logic                    sof_pulse,
  input  wire logic [10:0]             frame_number,
  input  wire logic                    usb_reset_pulse,
  output logic      [7:0]              dma_ptr,
  output logic      [7:0]              dma_len
);
  logic [7:0] mem      [0:255];
  logic [7:0] next_mem [0:255];
  logic [3:0] nset;
  logic [3:0] next_nset;
  logic [7:0] index;
  logic [7:0] next_index;
  logic [7:0] next_data_out;
  logic       wr_idle;
  logic       rd_idle;
  logic       next_wr_idle;
  logic       next_rd_idle;
  logic       host_wr;
  logic       host_rd;
  logic [7:0] next_buf_rdata;
  logic [7:0] next_dma_ptr;
  logic [7:0] next_dma_len;
  logic       next_rsp_valid;
  uers_pkg::uers_rsp_pkt_t next_rsp;
  uers_pkg::uers_rsp_t     tok_code;
  logic [7:0] tok_base;
  logic [7:0] tok_ctrl;
  logic [7:0] tok_ptr;
  logic [7:0] tok_len;
  logic       tok_ok;
  logic [7:0] done_base;
  logic [7:0] done_len;
  logic       done_ovf;
  logic       done_nset;
  logic [7:0] dma_base;

  // Set base: endpoint in bits 5:4, set b adds eight
  function automatic logic [7:0] set_base(input logic [1:0] ep, input logic b);
    return {2'b00, ep, b, 3'b000};
  endfunction

  function automatic logic is_set(input logic [7:0] a);
    return (a < uers_pkg::BUF_BASE) && (a[2:0] <= uers_pkg::OFS_LAST);
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] v;
    v = mem[a];
    if (is_set(a) && a[2:0] == uers_pkg::OFS_CTRL) begin
      v[uers_pkg::C_NEXT] = nset[a[5:4]];
      v[uers_pkg::C_RSVD] = 1'b0;
    end
    if (a == uers_pkg::CUR_SET) begin
      v = {4'h0, nset};
    end
    if (a == uers_pkg::FRM_LO) begin
      v = frame_number[7:0];
    end
    if (a == uers_pkg::FRM_HI) begin
      v = {5'h00, frame_number[10:8]};
    end
    return v;
  endfunction

  // Host port: strobes act on their leading edge only
  assign host_wr   = wr_idle & ~cs_n & ~wr_n;
  assign host_rd   = rd_idle & ~cs_n & ~rd_n;
  assign data_oe_n = cs_n | rd_n;

  always_comb begin
    next_index    = index;
    next_data_out = data_out;
    next_wr_idle  = cs_n | wr_n;
    next_rd_idle  = cs_n | rd_n;
    if (host_wr) begin
      if (register_index_select) begin
        next_index = index + 8'h01;
      end else begin
        next_index = data_in;
      end
    end
    if (host_rd) begin
      if (register_index_select) begin
        next_data_out = rd_byte(index);
        next_index    = index + 8'h01;
      end else begin
        next_data_out = index;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      index    <= 8'h00;
      data_out <= 8'h00;
      wr_idle  <= 1'b1;
      rd_idle  <= 1'b1;
    end else begin
      index    <= next_index;
      data_out <= next_data_out;
      wr_idle  <= next_wr_idle;
      rd_idle  <= next_rd_idle;
    end
  end

  // Token decision, shared by the answer and the status write-back
  always_comb begin
    tok_base = set_base(tok.ep, nset[tok.ep]);
    tok_ctrl = mem[tok_base];
    tok_ptr  = mem[{tok_base[7:3], uers_pkg::OFS_PTR}];
    tok_len  = mem[{tok_base[7:3], uers_pkg::OFS_LEN}];
    // SETUP is only legal on the control pipe
    tok_ok = mem[uers_pkg::DEV_CTRL][uers_pkg::D_USB_EN]
           && (tok.addr == mem[uers_pkg::DEV_ADDR][6:0])
           && tok_ctrl[uers_pkg::C_EN]
           && (tok.kind != uers_pkg::TOK_SETUP || tok.ep == 2'd0);
    tok_code = uers_pkg::RSP_IGNORE;
    if (tok_ok) begin
      if (tok_ctrl[uers_pkg::C_STALL] && tok.kind != uers_pkg::TOK_SETUP) begin
        tok_code = uers_pkg::RSP_STALL;
      end else if (!tok_ctrl[uers_pkg::C_ARM]) begin
        tok_code = uers_pkg::RSP_NAK;
      end else if (tok_ctrl[uers_pkg::C_DIR] != (tok.kind == uers_pkg::TOK_IN)) begin
        tok_code = uers_pkg::RSP_NAK;
      end else begin
        tok_code = uers_pkg::RSP_GO;
      end
    end
    next_rsp_valid = tok_valid;
    next_rsp.code  = tok_code;
    next_rsp.iso   = tok_ctrl[uers_pkg::C_ISO];
    next_rsp.seq   = tok_ctrl[uers_pkg::C_SEQ];
    next_rsp.ptr   = tok_ptr;
    next_rsp.len   = tok_len;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= next_rsp_valid;
      rsp       <= next_rsp;
    end
  end

  // Register and buffer memory; hardware updates come last so events win
  always_comb begin
    done_nset = nset[done.ep];
    done_base = set_base(done.ep, done_nset);
    done_len  = mem[{done_base[7:3], uers_pkg::OFS_LEN}];
    done_ovf  = done.count > done_len;
    dma_base  = set_base(2'd3, nset[3]);
    next_dma_ptr   = mem[{dma_base[7:3], uers_pkg::OFS_PTR}];
    next_dma_len   = mem[{dma_base[7:3], uers_pkg::OFS_LEN}];
    next_buf_rdata = mem[buf_addr];
    next_nset = nset;
    for (int i = 0; i < 256; i++) begin
      next_mem[i] = mem[i];
    end
    if (host_wr && register_index_select) begin
      if (index == uers_pkg::INT_STAT) begin
        next_mem[index] = mem[index] & ~data_in;
      end else if (index == uers_pkg::CUR_SET || index == uers_pkg::FRM_LO
                   || index == uers_pkg::FRM_HI) begin
        next_mem[index] = mem[index];
      end else if (is_set(index) && index[2:0] >= uers_pkg::OFS_STAT) begin
        next_mem[index] = mem[index];
      end else if (is_set(index) && index[2:0] == uers_pkg::OFS_CTRL) begin
        next_mem[index] = {1'b0, data_in[6:0]};
      end else begin
        next_mem[index] = data_in;
      end
    end
    if (buf_we && buf_addr >= uers_pkg::BUF_BASE) begin
      next_mem[buf_addr] = buf_wdata;
    end
    if (sof_pulse) begin
      next_mem[uers_pkg::INT_STAT][uers_pkg::I_SOF] = 1'b1;
    end
    if (usb_reset_pulse) begin
      next_mem[uers_pkg::INT_STAT][uers_pkg::I_RST] = 1'b1;
    end
    next_mem[uers_pkg::INT_STAT][uers_pkg::I_DMA] = 1'b0;
    if (tok_valid && tok_code == uers_pkg::RSP_NAK) begin
      next_mem[{tok_base[7:3], uers_pkg::OFS_STAT}] = 8'h40;
    end
    if (tok_valid && tok_code == uers_pkg::RSP_STALL) begin
      next_mem[{tok_base[7:3], uers_pkg::OFS_STAT}] = 8'h80;
    end
    if (done_valid) begin
      next_mem[{done_base[7:3], uers_pkg::OFS_STAT}] =
        {1'b0, 1'b0, done_ovf, done.setup, done.seq,
         done.tmo, done.err, done.ack};
      // Residual holds the excess on overflow instead of wrapping
      next_mem[{done_base[7:3], uers_pkg::OFS_RES}] =
        done_ovf ? done.count - done_len : done_len - done.count;
      next_mem[done_base][uers_pkg::C_ARM] = 1'b0;
      // Iso has no handshake, so the toggle stays put
      if (done.ack && !mem[done_base][uers_pkg::C_ISO]) begin
        next_mem[done_base][uers_pkg::C_SEQ] = ~mem[done_base][uers_pkg::C_SEQ];
      end
      next_nset[done.ep] = ~done_nset;
      next_mem[uers_pkg::INT_STAT][done.ep] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= uers_pkg::MEM_RST;
      end
      nset      <= 4'h0;
      buf_rdata <= 8'h00;
      dma_ptr   <= 8'h00;
      dma_len   <= 8'h00;
    end else begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= next_mem[i];
      end
      nset      <= next_nset;
      buf_rdata <= next_buf_rdata;
      dma_ptr   <= next_dma_ptr;
      dma_len   <= next_dma_len;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_ignore_off;
    tok_valid && !tok_ctrl[uers_pkg::C_EN] |=> rsp_valid && rsp.code == uers_pkg::RSP_IGNORE;
  endproperty
  a_ignore_off: assert property (p_ignore_off)
    else $error("disabled endpoint answered");

  property p_stall;
    tok_valid && tok_ok && tok_ctrl[uers_pkg::C_STALL] && tok.kind != uers_pkg::TOK_SETUP
      |=> rsp.code == uers_pkg::RSP_STALL
          && mem[{$past(tok_base[7:3]), uers_pkg::OFS_STAT}][uers_pkg::S_STALL];
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall not answered");

  property p_nak;
    tok_valid && tok_ok && !tok_ctrl[uers_pkg::C_STALL] && !tok_ctrl[uers_pkg::C_ARM]
      |=> rsp.code == uers_pkg::RSP_NAK;
  endproperty
  a_nak: assert property (p_nak)
    else $error("unarmed endpoint did not NAK");

  property p_params;
    tok_valid |=> rsp.ptr == $past(tok_ptr) && rsp.len == $past(tok_len);
  endproperty
  a_params: assert property (p_params)
    else $error("answer carries wrong pointer or length");

  property p_arm_clear;
    done_valid |=> !mem[$past(done_base)][uers_pkg::C_ARM];
  endproperty
  a_arm_clear: assert property (p_arm_clear)
    else $error("arm not cleared on completion");

  property p_set_flip;
    done_valid |=> nset[$past(done.ep)] != $past(done_nset);
  endproperty
  a_set_flip: assert property (p_set_flip)
    else $error("next set did not advance");

  property p_status;
    done_valid |=> mem[{$past(done_base[7:3]), uers_pkg::OFS_STAT}][5:0]
      == {$past(done_ovf), $past(done.setup), $past(done.seq),
          $past(done.tmo), $past(done.err), $past(done.ack)};
  endproperty
  a_status: assert property (p_status)
    else $error("packet status wrong");

  property p_residual;
    done_valid && !done_ovf |=> mem[{$past(done_base[7:3]), uers_pkg::OFS_RES}]
      == 8'($past(done_len) - $past(done.count));
  endproperty
  a_residual: assert property (p_residual)
    else $error("residual count wrong");

  property p_w1c;
    host_wr && register_index_select && index == uers_pkg::INT_STAT
      && !done_valid && !sof_pulse && !usb_reset_pulse
      |=> mem[uers_pkg::INT_STAT] == ($past(mem[uers_pkg::INT_STAT]) & ~$past(data_in));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("interrupt status clear wrong");

  property p_setup_ep;
    tok_valid && tok.kind == uers_pkg::TOK_SETUP && tok.ep != 2'd0
      |=> rsp.code == uers_pkg::RSP_IGNORE;
  endproperty
  a_setup_ep: assert property (p_setup_ep)
    else $error("setup on data endpoint answered");

  property p_go;
    tok_valid && tok_ok && !tok_ctrl[uers_pkg::C_STALL] && tok_ctrl[uers_pkg::C_ARM]
      && tok_ctrl[uers_pkg::C_DIR] == (tok.kind == uers_pkg::TOK_IN)
      |=> rsp.code == uers_pkg::RSP_GO;
  endproperty
  a_go: assert property (p_go)
    else $error("armed endpoint did not accept");

  property p_int_done;
    done_valid |=> mem[uers_pkg::INT_STAT][$past(done.ep)];
  endproperty
  a_int_done: assert property (p_int_done)
    else $error("endpoint done flag not set");

  property p_next_read;
    host_rd && register_index_select && is_set(index) && index[2:0] == uers_pkg::OFS_CTRL
      |=> data_out[uers_pkg::C_NEXT] == $past(nset[index[5:4]]);
  endproperty
  a_next_read: assert property (p_next_read)
    else $error("control read shows wrong next set");

  // Status and residual belong to the hardware; host writes must not land
  property p_ro_regs;
    host_wr && register_index_select && is_set(index) && index[2:0] >= uers_pkg::OFS_STAT
      && !done_valid && !tok_valid
      |=> mem[$past(index)] == $past(mem[index]);
  endproperty
  a_ro_regs: assert property (p_ro_regs)
    else $error("host changed a status byte");

  c_go:    cover property (tok_valid && tok_code == uers_pkg::RSP_GO ##[1:50] done_valid);
  c_nak:   cover property (tok_valid && tok_code == uers_pkg::RSP_NAK);
  c_stall: cover property (tok_valid && tok_code == uers_pkg::RSP_STALL);
  c_ovf:   cover property (done_valid && done_ovf);
  c_setup: cover property (tok_valid && tok.kind == uers_pkg::TOK_SETUP
                           && tok_code == uers_pkg::RSP_GO);
endmodule
`default_nettype wire

// [bench/uers_engine_model.sv]
`timescale 1ns/1ps
`default_nettype none
module uers_engine_model (
  input  wire logic                    clk,
  output var  logic                    tok_valid,
  output var  uers_pkg::uers_tok_req_t tok,
  input  wire logic                    rsp_valid,
  input  wire uers_pkg::uers_rsp_pkt_t rsp,
  output var  logic                    done_valid,
  output var  uers_pkg::uers_done_t    done,
  output var  logic                    buf_we,
  output var  logic [7:0]              buf_addr,
  output var  logic [7:0]              buf_wdata,
  input  wire logic [7:0]              buf_rdata,
  output var  logic                    sof_pulse,
  output var  logic [10:0]             frame_number,
  output var  logic                    usb_reset_pulse
);
  uers_pkg::uers_rsp_pkt_t last_rsp;
  logic                    got_rsp;
  initial begin
    {tok_valid, done_valid, buf_we, sof_pulse, usb_reset_pulse} = '0;
    {tok, done, buf_addr, buf_wdata, frame_number} = '0;
  end
  // Idle token, done and buffer write-data lines carry the inverse of the last value, so stale data never looks valid
  task automatic send_tok(input logic [1:0] ep, input uers_pkg::uers_tok_t k, input logic [6:0] a);
    tok = '{ep, k, a};
    tok_valid = 1'b1;
    @(posedge clk);
    #1;
    tok_valid = 1'b0;
    tok = ~tok;
    got_rsp = rsp_valid;
    last_rsp = rsp;
  endtask
  task automatic send_done(input uers_pkg::uers_done_t d);
    done = d;
    done_valid = 1'b1;
    @(posedge clk);
    #1;
    done_valid = 1'b0;
    done = ~d;
  endtask
  task automatic buf_wr(input logic [7:0] a, input logic [7:0] d);
    buf_addr = a;
    buf_wdata = d;
    buf_we = 1'b1;
    @(posedge clk);
    #1;
    buf_we = 1'b0;
    buf_wdata = ~d;
  endtask
  task automatic buf_rd(input logic [7:0] a, output logic [7:0] v);
    buf_addr = a;
    @(posedge clk);
    #1;
    v = buf_rdata;
  endtask
  task automatic events(input logic [10:0] fn);
    frame_number = fn;
    sof_pulse = 1'b1;
    @(posedge clk);
    #1;
    sof_pulse = 1'b0;
    usb_reset_pulse = 1'b1;
    @(posedge clk);
    #1;
    usb_reset_pulse = 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/usb_endpoint_register_set_test.sv]
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_register_set_test;
  logic                    clk, srst, cs_n, rd_n, wr_n, register_index_select;
  logic [7:0]              data_in, data_out, buf_addr, buf_wdata, buf_rdata, dma_ptr, dma_len;
  logic                    data_oe_n, tok_valid, rsp_valid, done_valid, buf_we;
  logic                    sof_pulse, usb_reset_pulse;
  logic [10:0]             frame_number;
  uers_pkg::uers_tok_req_t tok;
  uers_pkg::uers_rsp_pkt_t rsp;
  uers_pkg::uers_done_t    done;
  int                      num_errors, compares, cycles;
  logic [7:0]              v;
  uers_top uers_top_inst (.clk, .srst, .cs_n, .rd_n, .wr_n, .register_index_select,
    .data_in, .data_out, .data_oe_n, .tok_valid, .tok, .rsp_valid, .rsp, .done_valid,
    .done, .buf_we, .buf_addr, .buf_wdata, .buf_rdata, .sof_pulse, .frame_number,
    .usb_reset_pulse, .dma_ptr, .dma_len);
  uers_engine_model uers_engine_model_inst (.clk, .tok_valid, .tok, .rsp_valid, .rsp,
    .done_valid, .done, .buf_we, .buf_addr, .buf_wdata, .buf_rdata, .sof_pulse,
    .frame_number, .usb_reset_pulse);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] ptr_of(input logic [7:0] b);
    return 8'h80 | b;
  endfunction
  function automatic logic [7:0] len_of(input logic [7:0] b);
    return 8'h08 + {5'h0, b[5:3]};
  endfunction
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // One strobe, then a full idle cycle so the next strobe is seen as new
  task automatic hw(input logic s, input logic [7:0] d);
    {cs_n, wr_n, register_index_select, data_in} = {2'b00, s, d};
    @(posedge clk);
    #1;
    {cs_n, wr_n, data_in} = {2'b11, ~d};
    @(posedge clk);
    #1;
  endtask
  task automatic hr(output logic [7:0] r);
    {cs_n, rd_n, register_index_select} = 3'b001;
    @(posedge clk);
    #1;
    r = data_out;
    chk8("data oe", 8'h00, {7'h00, data_oe_n});
    {cs_n, rd_n} = 2'b11;
    @(posedge clk);
    #1;
    chk8("data oe idle", 8'h01, {7'h00, data_oe_n});
  endtask
  task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
    hw(1'b0, a);
    hw(1'b1, d);
  endtask
  task automatic rd_at(input logic [7:0] a, input string n, input logic [7:0] e);
    hw(1'b0, a);
    hr(v);
    chk8(n, e, v);
  endtask
  task automatic chk_set(input logic [7:0] b, c, p, l, s, r);
    logic [7:0] q[5];
    hw(1'b0, b);
    for (int i = 0; i < 5; i++) hr(q[i]);
    chk8("ctrl", c, q[0]);
    chk8("pointer", p, q[1]);
    chk8("length", l, q[2]);
    chk8("status", s, q[3]);
    chk8("residual", r, q[4]);
  endtask
  task automatic t_map();
    logic [7:0] b;
    for (int n = 0; n < 4; n++) for (int s = 0; s < 2; s++) begin
      b = 8'(n * 16 + s * 8);
      hw(1'b0, b + 8'h01);
      hw(1'b1, ptr_of(b));
      hw(1'b1, len_of(b));
      hw(1'b1, 8'hff);
      hw(1'b1, 8'hff);
      chk_set(b, 8'h00, ptr_of(b), len_of(b), 8'h00, 8'h00);
    end
    wr_at(8'h18, 8'hff);
    chk_set(8'h18, 8'h77, ptr_of(8'h18), len_of(8'h18), 8'h00, 8'h00);
    $display("map test done");
  endtask
  task automatic one_tok(input logic [1:0] ep, input uers_pkg::uers_tok_t k,
                         input logic [6:0] a, input logic [7:0] c, input uers_pkg::uers_rsp_t e);
    wr_at({2'b00, ep, 4'h0}, c);
    uers_engine_model_inst.send_tok(ep, k, a);
    chk8("rsp valid", 8'h01, {7'h0, uers_engine_model_inst.got_rsp});
    chk8("rsp code", {6'h0, e}, {6'h0, uers_engine_model_inst.last_rsp.code});
    if (e == uers_pkg::RSP_NAK) rd_at({2'b00, ep, 4'h3}, "nak status", 8'h40);
    if (e == uers_pkg::RSP_STALL) rd_at({2'b00, ep, 4'h3}, "stall status", 8'h80);
  endtask
  task automatic t_token();
    wr_at(uers_pkg::DEV_CTRL, 8'h01);
    wr_at(uers_pkg::DEV_ADDR, 8'h12);
    one_tok(2'd1, uers_pkg::TOK_IN, 7'h12, 8'h07, uers_pkg::RSP_GO);
    chk8("rsp ptr", ptr_of(8'h10), uers_engine_model_inst.last_rsp.ptr);
    chk8("rsp len", len_of(8'h10), uers_engine_model_inst.last_rsp.len);
    one_tok(2'd1, uers_pkg::TOK_IN, 7'h13, 8'h07, uers_pkg::RSP_IGNORE);
    one_tok(2'd1, uers_pkg::TOK_IN, 7'h12, 8'h05, uers_pkg::RSP_IGNORE);
    one_tok(2'd1, uers_pkg::TOK_IN, 7'h12, 8'h06, uers_pkg::RSP_NAK);
    one_tok(2'd1, uers_pkg::TOK_OUT, 7'h12, 8'h07, uers_pkg::RSP_NAK);
    one_tok(2'd1, uers_pkg::TOK_IN, 7'h12, 8'h27, uers_pkg::RSP_STALL);
    one_tok(2'd1, uers_pkg::TOK_SETUP, 7'h12, 8'h03, uers_pkg::RSP_IGNORE);
    one_tok(2'd0, uers_pkg::TOK_SETUP, 7'h12, 8'h23, uers_pkg::RSP_GO);
    one_tok(2'd1, uers_pkg::TOK_OUT, 7'h12, 8'h53, uers_pkg::RSP_GO);
    chk8("rsp iso seq", 8'h03, {6'h0, uers_engine_model_inst.last_rsp.iso,
                                uers_engine_model_inst.last_rsp.seq});
    wr_at(uers_pkg::DEV_CTRL, 8'h00);
    one_tok(2'd1, uers_pkg::TOK_OUT, 7'h12, 8'h53, uers_pkg::RSP_IGNORE);
    $display("token test done");
  endtask
  task automatic t_done();
    wr_at(8'h30, 8'h03);
    uers_engine_model_inst.send_done('{2'd3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'd17});
    chk_set(8'h30, 8'h4a, ptr_of(8'h30), 8'd14, 8'h21, 8'h03);
    chk8("dma ptr", ptr_of(8'h38), dma_ptr);
    rd_at(uers_pkg::CUR_SET, "current set", 8'h08);
    wr_at(8'h38, 8'h13);
    uers_engine_model_inst.send_done('{2'd3, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'd5});
    chk_set(8'h38, 8'h12, ptr_of(8'h38), 8'd15, 8'h0a, 8'h0a);
    chk8("dma len", 8'd14, dma_len);
    wr_at(8'h00, 8'h03);
    uers_engine_model_inst.send_done('{2'd0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'd8});
    chk_set(8'h00, 8'h4a, ptr_of(8'h00), 8'd8, 8'h15, 8'h00);
    rd_at(uers_pkg::CUR_SET, "current set", 8'h01);
    wr_at(uers_pkg::INT_STAT, 8'h00);
    rd_at(uers_pkg::INT_STAT, "int status", 8'h09);
    wr_at(uers_pkg::INT_STAT, 8'h08);
    rd_at(uers_pkg::INT_STAT, "int status", 8'h01);
    $display("done test done");
  endtask
  task automatic t_dev();
    uers_engine_model_inst.events(11'h5a3);
    wr_at(uers_pkg::INT_STAT, 8'h20);
    rd_at(uers_pkg::INT_STAT, "int status", 8'h41);
    rd_at(uers_pkg::FRM_LO, "frame low", 8'ha3);
    rd_at(uers_pkg::FRM_HI, "frame high", 8'h05);
    wr_at(uers_pkg::CUR_SET, 8'hff);
    rd_at(uers_pkg::CUR_SET, "current set", 8'h01);
    wr_at(uers_pkg::INT_EN, 8'h5c);
    rd_at(uers_pkg::INT_EN, "int enable", 8'h5c);
    wr_at(uers_pkg::DMA_HI, 8'h3a);
    rd_at(uers_pkg::DMA_HI, "dma count high", 8'h3a);
    uers_engine_model_inst.buf_wr(8'h90, 8'h3c);
    rd_at(8'h90, "buffer byte", 8'h3c);
    uers_engine_model_inst.buf_wr(8'h20, 8'hff);
    rd_at(8'h20, "dropped write", 8'h00);
    wr_at(8'h91, 8'h5e);
    uers_engine_model_inst.buf_rd(8'h91, v);
    chk8("engine read", 8'h5e, v);
    $display("device test done");
  endtask
  // Reset in mid-run must wipe the set selection, flags and control bytes
  task automatic t_reset();
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    chk8("data out after reset", 8'h00, data_out);
    rd_at(uers_pkg::CUR_SET, "current set after reset", 8'h00);
    rd_at(uers_pkg::INT_STAT, "int status after reset", 8'h00);
    rd_at(8'h00, "ctrl after reset", 8'h00);
    chk8("dma ptr after reset", 8'h00, dma_ptr);
    $display("reset test done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {clk, srst, cs_n, rd_n, wr_n, register_index_select, data_in} = {6'b011110, 8'h00};
    {num_errors, compares, cycles} = '0;
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    t_map();
    t_token();
    t_done();
    t_dev();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
